// [rtl/wts_preset_mem.sv]
// Purpose: Per-preset parameter store with registered read.
// Assumes: One write and one read port.
// Notes:   Entries never written read as the factory defaults.
`timescale 1ns/100ps
`include "wts_cfg.svh"
module wts_preset_mem (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic reset_n,
	// Write port
	input wire logic wr_en,
	input wire logic [3:0] wr_addr,
	input wire wts_pkg::wts_preset_t wr_data,
	// Read port
	input wire logic [3:0] rd_addr,
	output wts_pkg::wts_preset_t rd_data
);
	import wts_pkg::*;

	localparam wts_preset_t DFLT = '{arc_corr: `WTS_ARC_RST,
		postflow: `WTS_POST_RST, burnback: `WTS_BURN_RST,
		preflow: `WTS_PRE_RST};

	wts_preset_t mem [`WTS_NUM_PRESET];
	logic [`WTS_NUM_PRESET-1:0] used_r;

	always_ff @(posedge sys_clk) begin
		if (wr_en) begin
			mem[wr_addr] <= wr_data;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (!reset_n) begin
			used_r <= '0;
		end else if (wr_en) begin
			used_r[wr_addr] <= 1'b1;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (!reset_n) begin
			rd_data <= DFLT;
		end else begin
			rd_data <= used_r[rd_addr] ? mem[rd_addr] : DFLT;
		end
	end
endmodule : wts_preset_mem

// [rtl/wts_seq.sv]
// Purpose: Torch trigger sequencer: inching, four operating modes,
//          automatic cut-out and preset storage, with APB registers.
// Assumes: All inputs synchronous to sys_clk.
// Notes:   Settings are in milliseconds; arc correction in 0.1 V.
// Operation
// - Knob turned while inching steps inching speed by single units
// - Inching shows selected speed left, motor current right
// - Wire contact during inching stops the wire immediately
// - Spot, pause, wire speed global; others saved into active preset
// - Arc voltage correction clamped to -5 V .. +5 V per preset
// - Operating point shown as current, thickness or wire speed
// - No current 5 s after start raises ignition error, stops
// - Arc lost longer than 5 s raises arc fault, stops
// - Non-latched press: pre-flow, creep, preset speed on current; the code ramps up to it from creep speed here too
// - Non-latched release: wire stops, burn-back, then post-flow
// - Latched first press: pre-flow, creep, ignition, ramp to nominal
// - Latched first release and second press are ignored
// - Latched second release: wire stops, burn-back, post-flow
// - Spot: wire stops after spot time, then burn-back, post-flow
// - Interval: each weld stops at spot time, then burn-back
// - Interval: weld restarts automatically after pause time
// - Spot or interval: trigger release ends the process at once
// - Interval pause under 3 s: creep only in first spot
// - Preset change refused while welding current flows
//
// The placing of the registers and the APB register port are this design's own decisions.
`timescale 1ns/100ps
`include "wts_cfg.svh"
module wts_seq #(
	parameter int unsigned TICK_CYC = `WTS_MS_NS / `WTS_CLK_NS
) (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic reset_n,
	// Register bus
	input wire wts_pkg::wts_apb_req_t apb_req,
	output wts_pkg::wts_apb_rsp_t apb_rsp,
	// Operator controls
	input wire logic trigger,
	input wire logic inch_btn,
	input wire logic knob_step,
	input wire logic knob_up,
	// Power stage feedback
	input wire logic current_flow,
	input wire logic wire_contact,
	input wire logic [11:0] weld_current,
	input wire logic [11:0] motor_current,
	// Actuators
	output logic gas_valve,
	output logic wire_run,
	output logic [11:0] wire_speed,
	output logic power_on,
	output logic [7:0] arc_corr,
	// Displays and faults
	output logic [15:0] disp_left,
	output logic [15:0] disp_right,
	output logic ign_err,
	output logic arc_err
);
	import wts_pkg::*;

	// ----------------------------------------
	// Declarations
	// ----------------------------------------
	wts_state_t state_r, state_nxt;
	wts_mode_t mode_r;
	wts_form_t form_r;
	wts_preset_t cur, mem_wdata;
	logic [3:0] preset_r;
	logic [15:0] spot_r, pause_r;
	logic [11:0] wfs_r, inch_spd_r, creep_spd;
	logic [31:0] tick_cnt_r, prdata_r;
	logic tick, trig_r, trig_rise, trig_fall;
	logic ph_load, ph_done, flt_load, flt_done;
	logic [15:0] ph_val;
	logic [1:0] lat_stg_r;
	logic first_spot_r, rej_r, stop_req, in_proc, fault;
	logic setup, wr, mem_we;

	assign setup = apb_req.psel && !apb_req.penable;
	assign wr = apb_req.psel && apb_req.penable && apb_req.pwrite;

	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	function automatic logic reg_hit(input logic [7:0] a);
		case (a)
			`WTS_OFF_CTRL, `WTS_OFF_SPOT, `WTS_OFF_PAUSE, `WTS_OFF_WFS,
			`WTS_OFF_PRE, `WTS_OFF_BURN, `WTS_OFF_POST, `WTS_OFF_ARC,
			`WTS_OFF_STAT, `WTS_OFF_DISP: return 1'b1;
			default: return 1'b0;
		endcase
	endfunction : reg_hit

	function automatic logic [7:0] clamp_arc(input logic [7:0] v);
		if ($signed(v) > $signed(`WTS_ARC_MAX)) begin
			return `WTS_ARC_MAX;
		end else if ($signed(v) < $signed(`WTS_ARC_MIN)) begin
			return `WTS_ARC_MIN;
		end
		return v;
	endfunction : clamp_arc

	function automatic logic [11:0] ramp(input logic [11:0] s,
			input logic [11:0] t);
		if (s + `WTS_RAMP_STEP <= t && s < `WTS_SPD_MAX - `WTS_RAMP_STEP) begin
			return s + `WTS_RAMP_STEP;
		end
		return t;
	endfunction : ramp

	// ----------------------------------------
	// Millisecond tick and trigger edges
	// ----------------------------------------
	always_ff @(posedge sys_clk) begin
		if (!reset_n || tick_cnt_r == TICK_CYC - 1) begin
			tick_cnt_r <= 32'h00000000;
		end else begin
			tick_cnt_r <= tick_cnt_r + 32'h00000001;
		end
	end
	assign tick = (tick_cnt_r == TICK_CYC - 1);

	always_ff @(posedge sys_clk) begin
		if (!reset_n) begin
			trig_r <= 1'b0;
		end else begin
			trig_r <= trigger;
		end
	end
	assign trig_rise = trigger && !trig_r;
	assign trig_fall = !trigger && trig_r;

	// ----------------------------------------
	// Timers
	// ----------------------------------------
	// Spot time spans ramp and weld, so ramp-to-weld does not reload
	assign ph_load = (state_nxt != state_r) && (state_nxt != ST_WELD);
	always_comb begin
		case (state_nxt)
			ST_PREFLOW: ph_val = cur.preflow;
			ST_RAMP: ph_val = spot_r;
			ST_BURN: ph_val = cur.burnback;
			ST_PAUSE: ph_val = pause_r;
			ST_POSTFLOW: ph_val = cur.postflow;
			default: ph_val = 16'h0000;
		endcase
	end

	wts_timer u_phase (
		.sys_clk(sys_clk),
		.reset_n(reset_n),
		.load(ph_load),
		.load_val(ph_val),
		.tick(tick),
		.done(ph_done)
	);

	assign in_proc = state_r inside {ST_PREFLOW, ST_CREEP, ST_RAMP,
		ST_WELD};
	// Restarts on every flow of current while welding
	assign flt_load = !in_proc || (state_r inside {ST_RAMP, ST_WELD}
		&& current_flow);

	wts_timer u_fault (
		.sys_clk(sys_clk),
		.reset_n(reset_n),
		.load(flt_load),
		.load_val(`WTS_FAULT_MS),
		.tick(tick),
		.done(flt_done)
	);
	assign fault = in_proc && !flt_load && flt_done;

	// ----------------------------------------
	// Sequencer
	// ----------------------------------------
	always_comb begin
		case (mode_r)
			WTS_NONLATCH: stop_req = !trigger;
			WTS_LATCH: stop_req = trig_fall && lat_stg_r == 2'd2;
			default: stop_req = !trigger || ph_done;
		endcase
	end

	always_comb begin
		state_nxt = state_r;
		case (state_r)
			ST_IDLE: begin
				if (trig_rise) begin
					state_nxt = ST_PREFLOW;
				end else if (inch_btn) begin
					state_nxt = ST_INCH;
				end
			end
			ST_INCH: begin
				if (!inch_btn) begin
					state_nxt = ST_IDLE;
				end else if (wire_contact) begin
					state_nxt = ST_INCH_HOLD;
				end
			end
			ST_INCH_HOLD: begin
				if (!inch_btn) begin
					state_nxt = ST_IDLE;
				end
			end
			ST_PREFLOW, ST_CREEP: begin
				if (fault || (!trigger && mode_r != WTS_LATCH)) begin
					state_nxt = ST_POSTFLOW;
				end else if (state_r == ST_PREFLOW && ph_done) begin
					state_nxt = ST_CREEP;
				end else if (state_r == ST_CREEP && current_flow) begin
					state_nxt = ST_RAMP;
				end
			end
			ST_RAMP, ST_WELD: begin
				if (fault) begin
					state_nxt = ST_POSTFLOW;
				end else if (stop_req) begin
					state_nxt = ST_BURN;
				end else if (wire_speed == wfs_r) begin
					state_nxt = ST_WELD;
				end
			end
			ST_BURN: begin
				if (ph_done) begin
					if (mode_r == WTS_INTERVAL && trigger) begin
						state_nxt = ST_PAUSE;
					end else begin
						state_nxt = ST_POSTFLOW;
					end
				end
			end
			ST_PAUSE: begin
				if (!trigger) begin
					state_nxt = ST_POSTFLOW;
				end else if (ph_done) begin
					state_nxt = ST_CREEP;
				end
			end
			ST_POSTFLOW: begin
				if (ph_done) begin
					state_nxt = ST_IDLE;
				end
			end
			default: state_nxt = ST_IDLE;
		endcase
	end

	always_ff @(posedge sys_clk) begin
		if (!reset_n) begin
			state_r <= ST_IDLE;
		end else begin
			state_r <= state_nxt;
		end
	end

	// Latched trigger stages: 0 held, 1 released, 2 pressed again
	always_ff @(posedge sys_clk) begin
		if (!reset_n || state_r == ST_IDLE) begin
			lat_stg_r <= 2'd0;
		end else if (in_proc && lat_stg_r == 2'd0 && trig_fall) begin
			lat_stg_r <= 2'd1;
		end else if (in_proc && lat_stg_r == 2'd1 && trig_rise) begin
			lat_stg_r <= 2'd2;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (!reset_n || state_r == ST_IDLE) begin
			first_spot_r <= 1'b1;
		end else if (state_r == ST_PAUSE) begin
			first_spot_r <= 1'b0;
		end
	end

	// Short pauses skip creep so the next spot strikes at full speed
	assign creep_spd = (mode_r == WTS_INTERVAL && !first_spot_r &&
		pause_r < `WTS_SKIP_MS) ? wfs_r : `WTS_CREEP_SPD;

	// ----------------------------------------
	// Actuators
	// ----------------------------------------
	always_ff @(posedge sys_clk) begin
		if (!reset_n) begin
			wire_speed <= 12'h000;
		end else begin
			case (state_nxt)
				ST_INCH: wire_speed <= inch_spd_r;
				ST_CREEP: wire_speed <= creep_spd;
				ST_RAMP: begin
					if (state_r != ST_RAMP) begin
						wire_speed <= creep_spd;
					end else if (tick) begin
						wire_speed <= ramp(wire_speed, wfs_r);
					end
				end
				ST_WELD: wire_speed <= wfs_r;
				default: wire_speed <= 12'h000;
			endcase
		end
	end

	always_ff @(posedge sys_clk) begin
		if (!reset_n) begin
			wire_run <= 1'b0;
			gas_valve <= 1'b0;
			power_on <= 1'b0;
		end else begin
			wire_run <= state_nxt inside {ST_INCH, ST_CREEP, ST_RAMP,
				ST_WELD};
			gas_valve <= !(state_nxt inside {ST_IDLE, ST_INCH,
				ST_INCH_HOLD});
			power_on <= state_nxt inside {ST_CREEP, ST_RAMP, ST_WELD,
				ST_BURN};
		end
	end

	always_ff @(posedge sys_clk) begin
		if (!reset_n) begin
			inch_spd_r <= `WTS_INCH_RST;
		end else if (inch_btn && knob_step) begin
			if (knob_up && inch_spd_r != `WTS_SPD_MAX) begin
				inch_spd_r <= inch_spd_r + 12'h001;
			end else if (!knob_up && inch_spd_r != 12'h000) begin
				inch_spd_r <= inch_spd_r - 12'h001;
			end
		end
	end

	// ----------------------------------------
	// Displays
	// ----------------------------------------
	always_ff @(posedge sys_clk) begin
		if (!reset_n) begin
			disp_left <= 16'h0000;
			disp_right <= 16'h0000;
		end else if (state_r inside {ST_INCH, ST_INCH_HOLD}) begin
			disp_left <= {4'h0, inch_spd_r};
			disp_right <= {4'h0, motor_current};
		end else begin
			case (form_r)
				WTS_SHOW_CUR: disp_left <= {4'h0, weld_current};
				WTS_SHOW_THK: disp_left <= 16'(wfs_r >> `WTS_THK_SHIFT);
				default: disp_left <= {4'h0, wfs_r};
			endcase
			disp_right <= {{8{cur.arc_corr[7]}}, cur.arc_corr};
		end
	end

	// ----------------------------------------
	// Faults and preset refusal, set wins over clear
	// ----------------------------------------
	always_ff @(posedge sys_clk) begin
		if (!reset_n) begin
			ign_err <= 1'b0;
			arc_err <= 1'b0;
			rej_r <= 1'b0;
		end else begin
			ign_err <= (fault && state_r inside {ST_PREFLOW, ST_CREEP})
				|| (ign_err && !(wr && apb_req.paddr == `WTS_OFF_STAT
				&& apb_req.pwdata[`WTS_B_IGN]));
			arc_err <= (fault && state_r inside {ST_RAMP, ST_WELD})
				|| (arc_err && !(wr && apb_req.paddr == `WTS_OFF_STAT
				&& apb_req.pwdata[`WTS_B_ARC]));
			rej_r <= (wr && apb_req.paddr == `WTS_OFF_CTRL && current_flow)
				|| (rej_r && !(wr && apb_req.paddr == `WTS_OFF_STAT
				&& apb_req.pwdata[`WTS_B_REJ]));
		end
	end

	// ----------------------------------------
	// Register writes
	// ----------------------------------------
	always_ff @(posedge sys_clk) begin
		if (!reset_n) begin
			mode_r <= WTS_NONLATCH;
			form_r <= WTS_SHOW_WFS;
			preset_r <= 4'h0;
			spot_r <= `WTS_SPOT_RST;
			pause_r <= `WTS_PAUSE_RST;
			wfs_r <= `WTS_WFS_RST;
		end else if (wr) begin
			case (apb_req.paddr)
				`WTS_OFF_CTRL: begin
					mode_r <= wts_mode_t'(apb_req.pwdata[`WTS_F_MODE]);
					form_r <= wts_form_t'(apb_req.pwdata[`WTS_F_FORM]);
					if (!current_flow) begin
						preset_r <= apb_req.pwdata[`WTS_F_PRESET];
					end
				end
				`WTS_OFF_SPOT: spot_r <= apb_req.pwdata[`WTS_F_MS];
				`WTS_OFF_PAUSE: pause_r <= apb_req.pwdata[`WTS_F_MS];
				`WTS_OFF_WFS: wfs_r <= apb_req.pwdata[`WTS_F_WFS];
				default: ;
			endcase
		end
	end

	// Per-preset fields are written through into the active preset
	always_comb begin
		mem_wdata = cur;
		mem_we = wr;
		case (apb_req.paddr)
			`WTS_OFF_PRE: mem_wdata.preflow = apb_req.pwdata[`WTS_F_MS];
			`WTS_OFF_BURN: mem_wdata.burnback = apb_req.pwdata[`WTS_F_MS];
			`WTS_OFF_POST: mem_wdata.postflow = apb_req.pwdata[`WTS_F_MS];
			`WTS_OFF_ARC: mem_wdata.arc_corr =
				clamp_arc(apb_req.pwdata[`WTS_F_ARC]);
			default: mem_we = 1'b0;
		endcase
	end

	wts_preset_mem u_mem (
		.sys_clk(sys_clk),
		.reset_n(reset_n),
		.wr_en(mem_we),
		.wr_addr(preset_r),
		.wr_data(mem_wdata),
		.rd_addr(preset_r),
		.rd_data(cur)
	);
	assign arc_corr = cur.arc_corr;

	// ----------------------------------------
	// Register reads, captured in the setup cycle
	// ----------------------------------------
	always_ff @(posedge sys_clk) begin
		if (!reset_n) begin
			prdata_r <= 32'h00000000;
		end else if (setup && !apb_req.pwrite) begin
			case (apb_req.paddr)
				`WTS_OFF_CTRL: prdata_r <= {24'h000000, preset_r, form_r,
					mode_r};
				`WTS_OFF_SPOT: prdata_r <= {16'h0000, spot_r};
				`WTS_OFF_PAUSE: prdata_r <= {16'h0000, pause_r};
				`WTS_OFF_WFS: prdata_r <= {20'h00000, wfs_r};
				`WTS_OFF_PRE: prdata_r <= {16'h0000, cur.preflow};
				`WTS_OFF_BURN: prdata_r <= {16'h0000, cur.burnback};
				`WTS_OFF_POST: prdata_r <= {16'h0000, cur.postflow};
				`WTS_OFF_ARC: prdata_r <= {24'h000000, cur.arc_corr};
				`WTS_OFF_STAT: prdata_r <= {24'h000000, state_r, 1'b0,
					rej_r, arc_err, ign_err};
				`WTS_OFF_DISP: prdata_r <= {disp_right, disp_left};
				default: prdata_r <= 32'h00000000;
			endcase
		end
	end

	assign apb_rsp.prdata = prdata_r;
	assign apb_rsp.pready = 1'b1;
	assign apb_rsp.pslverr = apb_req.psel && apb_req.penable &&
		!reg_hit(apb_req.paddr);

	// ----------------------------------------
	// Assertions
	// ----------------------------------------
	inch_stop_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
		state_r == ST_INCH && wire_contact |=> !wire_run && wire_speed == 0)
		else $error("wire kept running after contact");
	knob_step_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
		inch_btn && knob_step && knob_up && inch_spd_r != `WTS_SPD_MAX
		|=> inch_spd_r == $past(inch_spd_r) + 12'h001)
		else $error("inching speed did not step up");
	preset_lock_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
		wr && apb_req.paddr == `WTS_OFF_CTRL && current_flow
		|=> $stable(preset_r) && rej_r)
		else $error("preset changed under current");
	arc_range_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
		$signed(cur.arc_corr) <= $signed(`WTS_ARC_MAX) &&
		$signed(cur.arc_corr) >= $signed(`WTS_ARC_MIN))
		else $error("arc correction out of range");
	ign_fault_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
		fault && state_r == ST_CREEP |=> ign_err && !power_on
		&& state_r == ST_POSTFLOW)
		else $error("ignition error not raised");
	arc_fault_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
		fault && state_r == ST_WELD |=> arc_err && !power_on)
		else $error("arc interruption not handled");
	nl_release_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
		mode_r == WTS_NONLATCH && state_r == ST_WELD && !trigger && !fault
		|=> state_r == ST_BURN && !wire_run && power_on && gas_valve)
		else $error("non-latched release mishandled");
	latch_hold_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
		mode_r == WTS_LATCH && state_r == ST_WELD && lat_stg_r != 2'd2
		&& !fault |=> state_r == ST_WELD)
		else $error("latched weld ended early");
	spot_end_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
		mode_r == WTS_SPOT && state_r == ST_WELD && ph_done && !fault
		|=> state_r == ST_BURN ##1 !wire_run)
		else $error("spot time did not stop wire");
	pause_go_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
		state_r == ST_PAUSE && ph_done && trigger |=> state_r == ST_CREEP)
		else $error("interval did not restart");
	post_idle_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
		state_r == ST_POSTFLOW && ph_done |=> state_r == ST_IDLE
		&& !gas_valve)
		else $error("post-flow end did not idle");
endmodule : wts_seq

// [rtl/wts_timer.sv]
// Purpose: Millisecond down-counter for sequence intervals.
// Assumes: tick is a one-cycle pulse per millisecond.
// Notes:   done stays high while the count rests at zero.
`timescale 1ns/100ps
module wts_timer (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic reset_n,
	// Control
	input wire logic load,
	input wire logic [15:0] load_val,
	input wire logic tick,
	// Status
	output logic done
);
	logic [15:0] cnt_r;

	always_ff @(posedge sys_clk) begin
		if (!reset_n) begin
			cnt_r <= 16'h0000;
		end else if (load) begin
			cnt_r <= load_val;
		end else if (tick && cnt_r != 16'h0000) begin
			cnt_r <= cnt_r - 16'h0001;
		end
	end

	assign done = (cnt_r == 16'h0000);
endmodule : wts_timer

// [shared/wts_cfg.svh]
// Purpose: Offsets, field positions, reset values and timing figures
//          for the welding trigger sequencer.
// Assumes: 100 MHz system clock, settings counted in milliseconds.
// Notes:   Definitions only.
`ifndef WTS_CFG_SVH
`define WTS_CFG_SVH

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define WTS_OFF_CTRL 8'h00
`define WTS_OFF_SPOT 8'h04
`define WTS_OFF_PAUSE 8'h08
`define WTS_OFF_WFS 8'h0C
`define WTS_OFF_PRE 8'h10
`define WTS_OFF_BURN 8'h14
`define WTS_OFF_POST 8'h18
`define WTS_OFF_ARC 8'h1C
`define WTS_OFF_STAT 8'h20
`define WTS_OFF_DISP 8'h24

// ----------------------------------------
// Fields
// ----------------------------------------
`define WTS_F_MODE 1:0
`define WTS_F_FORM 3:2
`define WTS_F_PRESET 7:4
`define WTS_F_MS 15:0
`define WTS_F_WFS 11:0
`define WTS_F_ARC 7:0
`define WTS_B_IGN 0
`define WTS_B_ARC 1
`define WTS_B_REJ 2
`define WTS_F_STATE 7:4
`define WTS_NUM_PRESET 16

// ----------------------------------------
// Reset values
// ----------------------------------------
`define WTS_SPOT_RST 16'h01F4
`define WTS_PAUSE_RST 16'h03E8
`define WTS_WFS_RST 12'h200
`define WTS_PRE_RST 16'h0064
`define WTS_BURN_RST 16'h0032
`define WTS_POST_RST 16'h01F4
`define WTS_ARC_RST 8'h00
`define WTS_INCH_RST 12'h100

// ----------------------------------------
// Speeds and timing
// ----------------------------------------
`define WTS_CREEP_SPD 12'h040
`define WTS_RAMP_STEP 12'h010
`define WTS_SPD_MAX 12'hFFF
`define WTS_THK_SHIFT 6
`define WTS_ARC_MAX 8'h32
`define WTS_ARC_MIN 8'hCE
`define WTS_CLK_NS 10
`define WTS_MS_NS 1000000
`define WTS_MS_PER_S 1000
`define WTS_FAULT_S 5
`define WTS_SKIP_S 3
`define WTS_FAULT_MS 16'(`WTS_FAULT_S * `WTS_MS_PER_S)
`define WTS_SKIP_MS 16'(`WTS_SKIP_S * `WTS_MS_PER_S)

`endif

// [shared/wts_pkg.sv]
// Purpose: Types of the welding trigger sequencer.
// Assumes: Constants live in wts_cfg.svh.
// Notes:   None.
package wts_pkg;

	typedef enum logic [1:0] {
		WTS_NONLATCH, WTS_LATCH, WTS_SPOT, WTS_INTERVAL
	} wts_mode_t;

	typedef enum logic [1:0] {
		WTS_SHOW_CUR, WTS_SHOW_THK, WTS_SHOW_WFS, WTS_SHOW_RSV
	} wts_form_t;

	typedef enum logic [3:0] {
		ST_IDLE, ST_INCH, ST_INCH_HOLD, ST_PREFLOW, ST_CREEP,
		ST_RAMP, ST_WELD, ST_BURN, ST_PAUSE, ST_POSTFLOW
	} wts_state_t;

	typedef struct packed {
		logic [7:0] arc_corr;
		logic [15:0] postflow;
		logic [15:0] burnback;
		logic [15:0] preflow;
	} wts_preset_t;

	typedef struct packed {
		logic [7:0] paddr;
		logic psel;
		logic penable;
		logic pwrite;
		logic [31:0] pwdata;
	} wts_apb_req_t;

	typedef struct packed {
		logic [31:0] prdata;
		logic pready;
		logic pslverr;
	} wts_apb_rsp_t;

endpackage : wts_pkg

// [tb/test_welding_trigger_sequencer.sv]
// Purpose: Self-checking bench for the welding trigger sequencer.
// Assumes: TICK_CYC of 4, so one millisecond is 4 cycles.
// Notes:   Settings shrunk so each sequence takes a few hundred cycles; the two 5 s fault cases take about 20000.
`timescale 1ns/100ps
module test_welding_trigger_sequencer;
	import wts_pkg::*;
	logic sys_clk = 0, reset_n = 0, trigger = 0, inch_btn = 0, hit = 0;
	logic knob_step = 0, knob_up = 0, current_flow, wire_contact;
	logic gas_valve, wire_run, power_on, ign_err, arc_err, perr;
	logic [11:0] weld_current, motor_current, wire_speed;
	logic [7:0] arc_corr;
	logic [15:0] disp_left, disp_right;
	logic [31:0] rd, d, seed = 32'hB317;
	logic [4:0] obs;
	wts_apb_req_t req = '0;
	wts_apb_rsp_t rsp;
	int n_errors = 0, samples_checked = 0;
	int exp_r[int] = '{4:500, 8:1000, 12:'h200, 16:100, 20:50, 24:500, 28:0};
	int set_a[6] = '{4, 8, 12, 16, 20, 24}, set_v[6] = '{20, 10, 128, 5, 3, 5};
	int arc_i[3] = '{'h7F, 'h80, 'hFB}, arc_e[3] = '{'h32, 'hCE, 'hFB};
	localparam int b_pw = 0, b_wr = 1, b_gas = 2, b_nom = 3, b_ign = 4;
	assign obs = {ign_err, wire_speed === 12'h080, gas_valve, wire_run, power_on};
	always #5 sys_clk = ~sys_clk;
	wts_seq #(.TICK_CYC(4)) wts_seq_inst (.sys_clk(sys_clk),
		.reset_n(reset_n), .apb_req(req), .apb_rsp(rsp), .trigger(trigger),
		.inch_btn(inch_btn), .knob_step(knob_step), .knob_up(knob_up),
		.current_flow(current_flow), .wire_contact(wire_contact),
		.weld_current(weld_current), .motor_current(motor_current),
		.gas_valve(gas_valve), .wire_run(wire_run), .wire_speed(wire_speed),
		.power_on(power_on), .arc_corr(arc_corr), .disp_left(disp_left),
		.disp_right(disp_right), .ign_err(ign_err), .arc_err(arc_err));
	wts_stage wts_stage_inst (.sys_clk(sys_clk), .hit(hit),
		.wire_run(wire_run), .power_on(power_on), .wire_contact(wire_contact),
		.current_flow(current_flow), .weld_current(weld_current),
		.motor_current(motor_current));
	// ----
	// Tasks
	// ----
	function logic [31:0] xs();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction : xs
	task chk(input logic [31:0] got, input logic [31:0] exp);
		samples_checked++;
		if (got !== exp) begin
			n_errors++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk
	task apb(input logic w, input logic [7:0] a, input logic [31:0] v);
		req <= '{a, 1'b1, 1'b0, w, v};
		@(posedge sys_clk);
		req.penable <= 1'b1;
		do @(posedge sys_clk); while (rsp.pready !== 1'b1);
		rd = rsp.prdata;
		perr = rsp.pslverr;
		req.psel <= 1'b0;
		req.penable <= 1'b0;
		@(posedge sys_clk);
	endtask : apb
	task rc(input logic [7:0] a, input logic [31:0] e);
		apb(1'b0, a, 0);
		chk(rd, e);
	endtask : rc
	// Sample at the falling edge so outputs have settled
	task wfor(input int b, input logic v, input int n);
		do begin
			@(negedge sys_clk);
			n--;
		end while (obs[b] !== v && n > 0);
		chk(obs[b], v);
		@(posedge sys_clk);
	endtask : wfor
	task test_done();
		$display("errors %0d checks %0d", n_errors, samples_checked);
		if (n_errors == 0 && samples_checked > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask : test_done
	initial begin
		#600000;
		n_errors++;
		test_done();
	end
	// ----
	// Scenarios
	// ----
	initial begin
		repeat (8) @(posedge sys_clk);
		reset_n <= 1'b1;
		@(posedge sys_clk);
		foreach (exp_r[a]) rc(8'(a), exp_r[a]);
		rc(8'h40, 0);
		chk(perr, 1);
		for (int a = 4; a <= 12; a += 4) begin
			d = xs();
			apb(1'b1, 8'(a), d);
			rc(8'(a), d & (a == 12 ? 'hFFF : 'hFFFF));
		end
		foreach (set_a[i]) apb(1'b1, 8'(set_a[i]), set_v[i]);
		apb(1'b1, 8'h00, 32'h10);
		apb(1'b1, 8'h10, 7);
		apb(1'b1, 8'h00, 0);
		rc(8'h10, 5);
		foreach (arc_i[i]) begin
			apb(1'b1, 8'h1C, arc_i[i]);
			rc(8'h1C, arc_e[i]);
			chk(arc_corr, arc_e[i]);
		end
		for (int f = 0; f < 4; f++) begin
			apb(1'b1, 8'h00, f << 2);
			rc(8'h00, f << 2);
			chk(disp_left, f == 0 ? 0 : (f == 1 ? 2 : 'h80));
		end
		inch_btn <= 1'b1;
		knob_up <= 1'b1;
		wfor(b_wr, 1, 5);
		chk(wire_speed, 12'h100);
		knob_step <= 1'b1;
		@(posedge sys_clk);
		knob_step <= 1'b0;
		repeat (3) @(negedge sys_clk);
		chk(wire_speed, 12'h101);
		chk(disp_left, 16'h0101);
		chk(disp_right, 16'h0123);
		@(posedge sys_clk);
		hit <= 1'b1;
		wfor(b_wr, 0, 30);
		inch_btn <= 1'b0;
		for (int m = 8; m < 12; m++) begin
			apb(1'b1, 8'h00, m);
			trigger <= 1'b1;
			wfor(b_gas, 1, 3);
			wfor(b_wr, 1, 70);
			chk(wire_speed, 12'h040);
			wfor(b_nom, 1, 200);
			if (m == 9) begin
				trigger <= 1'b0;
				repeat (20) @(posedge sys_clk);
				chk(wire_run, 1);
				trigger <= 1'b1;
				apb(1'b1, 8'h00, 32'h29);
				rc(8'h00, 32'h9);
				rc(8'h20, 32'h64);
				chk(wire_run, 1);
			end
			if (m >= 10) begin
				wfor(b_wr, 0, 230);
				chk(power_on, 1);
			end
			if (m == 11) begin
				wfor(b_wr, 1, 200);
				chk(wire_speed, 12'h080);
			end
			if (m == 10)
				wfor(b_gas, 0, 150);
			trigger <= 1'b0;
			repeat (2) @(negedge sys_clk);
			chk(wire_run, 0);
			wfor(b_gas, 0, 150);
		end
		hit <= 1'b0;
		apb(1'b1, 8'h00, 32'h8);
		trigger <= 1'b1;
		repeat (19600) @(posedge sys_clk);
		chk(ign_err, 0);
		wfor(b_ign, 1, 2000);
		chk(power_on, 0);
		trigger <= 1'b0;
		apb(1'b0, 8'h20, 0);
		chk(rd[0], 1);
		apb(1'b1, 8'h20, 32'h7);
		apb(1'b0, 8'h20, 0);
		chk(rd[2:0], 0);
		// Arc lost in mid-weld: workpiece pulled away
		wfor(b_gas, 0, 150);
		hit <= 1'b1;
		trigger <= 1'b1;
		wfor(b_nom, 1, 200);
		hit <= 1'b0;
		repeat (19600) @(posedge sys_clk);
		chk(arc_err, 0);
		wfor(b_pw, 0, 2000);
		chk(arc_err, 1);
		trigger <= 1'b0;
		test_done();
	end
endmodule : test_welding_trigger_sequencer

// [tb/wts_stage.sv]
// Purpose: Power stage and workpiece model for the sequencer bench.
// Assumes: Contact is possible only while hit is high.
// Notes:   Current flows only with output on and contact.
`timescale 1ns/100ps
module wts_stage (
	// Clock
	input wire logic sys_clk,
	// Sequencer side
	input wire logic hit,
	input wire logic wire_run,
	input wire logic power_on,
	output logic wire_contact,
	output logic current_flow,
	output logic [11:0] weld_current,
	output logic [11:0] motor_current
);
	int run_cnt = 0;
	// Wire needs a short run before it meets the workpiece
	always @(posedge sys_clk) begin
		if (!hit)
			run_cnt <= 0;
		else if (wire_run && run_cnt < 20)
			run_cnt <= run_cnt + 1;
	end
	assign wire_contact = hit && run_cnt >= 20;
	assign current_flow = wire_contact && power_on;
	assign weld_current = current_flow ? 12'h0C8 : 12'h000;
	assign motor_current = wire_run ? 12'h123 : 12'h000;
endmodule : wts_stage
